// [flash_status_pkg.sv]
// Constants and types shared by the status flag logic.
package flash_status_pkg;
    // ------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------
    localparam int BIT_IDLE = 7;
    localparam int BIT_ERASE_SUSP = 6;
    localparam int BIT_ERASE_FAIL = 5;
    localparam int BIT_PROG_FAIL = 4;
    localparam int BIT_SUPPLY_ERR = 3;
    localparam int BIT_PROG_SUSP = 2;
    localparam int BIT_PROTECT_ERR = 1;
    localparam int BIT_RESERVED = 0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] BUSY_OE_MASK = 8'h80;
    localparam logic [7:0] FULL_OE_MASK = 8'hff;
    localparam logic [7:0] NO_OE_MASK = 8'h00;
    localparam logic PIN_INACTIVE = 1'b1;

    // ------------------------------------------------------------
    // Operation kinds and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_WORD_PROGRAM = 3'b000,
        OP_BUFFER_PROGRAM = 3'b001,
        OP_ERASE = 3'b010,
        OP_PROTECT = 3'b011,
        OP_UNPROTECT = 3'b100
    } opkind_t;
    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_SUSP_WAIT = 2'b01
    } runstate_t;
    typedef enum logic {
        MODE_ARRAY = 1'b0,
        MODE_STATUS = 1'b1
    } readmode_t;
endpackage

// [flag_if.sv]
// Events into the status flag register and the status byte out of it.
`timescale 1ns/1ns
interface flag_if;
    import flash_status_pkg::*;
    logic opStart;
    opkind_t opKind;
    logic ctrlActive;
    logic ctrlPaused;
    logic cmdSuspend;
    logic cmdResume;
    logic cmdClear;
    logic opFail;
    logic failVpp;
    logic failProtected;
    logic failSequence;
    logic [7:0] statusByte;
    modport owner(output opStart, opKind, ctrlActive, ctrlPaused, cmdSuspend, cmdResume, cmdClear,
        opFail, failVpp, failProtected, failSequence, input statusByte);
    modport flags(input opStart, opKind, ctrlActive, ctrlPaused, cmdSuspend, cmdResume, cmdClear,
        opFail, failVpp, failProtected, failSequence, output statusByte);
endinterface

// [status_flags.sv]
// Suspend tracking and sticky error flags of the status byte.
`timescale 1ns/1ns
module status_flags (
    input wire logic mclk,
    input wire logic rst,
    flag_if.flags fl
);
    import flash_status_pkg::*;
    runstate_t runState_reg, runState_next;
    logic curErase_reg, curErase_next;
    logic [7:0] flags_reg, flags_next;
    logic eraseKind;
    logic [7:0] setBits;

    always_comb begin
        eraseKind = (fl.opKind == OP_ERASE) || (fl.opKind == OP_UNPROTECT);
        runState_next = runState_reg;
        curErase_next = curErase_reg;
        setBits = 8'h00;
        if (fl.opStart) begin
            curErase_next = eraseKind;
        end
        unique case (runState_reg)
            RUN_IDLE: begin
                if (fl.cmdSuspend && fl.ctrlActive) begin
                    runState_next = RUN_SUSP_WAIT;
                end
            end
            RUN_SUSP_WAIT: begin
                if (fl.ctrlPaused) begin
                    runState_next = RUN_IDLE;
                    setBits[curErase_reg ? BIT_ERASE_SUSP : BIT_PROG_SUSP] = 1'b1;
                end else if (!fl.ctrlActive) begin
                    // Finishing instead of pausing sets neither suspend flag.
                    runState_next = RUN_IDLE;
                end
            end
            default: runState_next = RUN_IDLE;
        endcase
        if (fl.cmdResume) begin
            curErase_next = !flags_reg[BIT_PROG_SUSP];
        end
        if (fl.opFail) begin
            if (eraseKind) begin
                setBits[BIT_ERASE_FAIL] = 1'b1;
                setBits[BIT_SUPPLY_ERR] = fl.failVpp;
                setBits[BIT_PROTECT_ERR] = fl.failProtected;
                setBits[BIT_PROG_FAIL] = fl.failSequence;
            end else begin
                setBits[BIT_PROG_FAIL] = 1'b1;
                // The supply check is not made for buffered programming.
                setBits[BIT_SUPPLY_ERR] = fl.failVpp && (fl.opKind != OP_BUFFER_PROGRAM);
                setBits[BIT_PROTECT_ERR] = fl.failProtected;
                setBits[BIT_ERASE_FAIL] = fl.failSequence;
            end
        end
        flags_next = flags_reg;
        if (fl.cmdClear) begin
            flags_next[BIT_ERASE_FAIL] = 1'b0;
            flags_next[BIT_PROG_FAIL] = 1'b0;
            flags_next[BIT_SUPPLY_ERR] = 1'b0;
            flags_next[BIT_PROTECT_ERR] = 1'b0;
        end
        if (fl.cmdResume) begin
            // A suspended program is resumed first, then a suspended erase.
            if (flags_reg[BIT_PROG_SUSP]) begin
                flags_next[BIT_PROG_SUSP] = 1'b0;
            end else begin
                flags_next[BIT_ERASE_SUSP] = 1'b0;
            end
        end
        flags_next = flags_next | setBits;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            runState_reg <= RUN_IDLE;
            curErase_reg <= 1'b0;
            flags_reg <= 8'h00;
        end else begin
            runState_reg <= runState_next;
            curErase_reg <= curErase_next;
            flags_reg <= flags_next;
        end
    end

    always_comb begin
        fl.statusByte = flags_reg;
        fl.statusByte[BIT_IDLE] = !(fl.ctrlActive || runState_reg == RUN_SUSP_WAIT);
        fl.statusByte[BIT_RESERVED] = 1'b0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_sticky_erase_fail: assert property (flags_reg[BIT_ERASE_FAIL] && !fl.cmdClear |=> flags_reg[BIT_ERASE_FAIL])
        else $error("erase fail flag dropped without clear");
    a_suspend_holds_busy: assert property (fl.cmdSuspend && fl.ctrlActive && runState_reg == RUN_IDLE
        |=> !fl.statusByte[BIT_IDLE]) else $error("idle shown before pause");
    a_erase_susp_set: assert property (runState_reg == RUN_SUSP_WAIT && fl.ctrlPaused && curErase_reg
        && !fl.cmdResume |=> flags_reg[BIT_ERASE_SUSP]) else $error("erase suspend flag not set");
    a_resume_clears: assert property (fl.cmdResume && flags_reg[BIT_PROG_SUSP] && !fl.ctrlPaused
        |=> !flags_reg[BIT_PROG_SUSP]) else $error("program suspend flag not cleared");
    a_erase_failure: assert property (fl.opFail && fl.opKind == OP_ERASE
        |=> flags_reg[BIT_ERASE_FAIL] && flags_reg[BIT_PROTECT_ERR] == $past(fl.failProtected | flags_reg[1]))
        else $error("erase failure bits wrong");
    a_prog_failure: assert property (fl.opFail && fl.opKind == OP_WORD_PROGRAM && fl.failSequence
        |=> flags_reg[BIT_PROG_FAIL] && flags_reg[BIT_ERASE_FAIL]) else $error("program failure bits wrong");
endmodule // status_flags

// [flash_op_status_flags.sv]
// Status register read path of the flash: pin sync, read mode and output drive.
//
// How it works
// - Status flags drive the low data byte during a status read.
// - Program, erase, protect, unprotect and resume switch reads to status, any address.
// - Status reads are asynchronous; array mode restores the stored burst setting.
// - Output contents refresh on output enable toggle or chip enable re-selection.
// - Error bits 5, 4, 3, 1 stay set until clear command or reset.
// - Bit 7 low while controller active, other bits undriven; high when idle.
// - After suspend, bit 7 stays low until the controller really pauses.
// - Bit 6 high only when an erase is suspended awaiting resume.
// - Resume returns the erase suspended flag low.
// - Bit 5 alone: erase or unprotect failed verify after maximum pulses.
// - Erase failure adds bit 3 supply low, bit 1 protected, bit 4 sequence.
// - Bit 4 set on program or block protect failure.
// - Program failure adds bit 3 supply low, bit 1 protected, bit 5 sequence.
// - Bit 3 flags a supply-low attempt; ignored for buffered programming.
// - Bit 2 high only when a program is suspended awaiting resume.
// - Resume returns the program suspended flag low.
// - Bit 1 flags a protected-block attempt together with the failure bit.
`timescale 1ns/1ns
module flash_op_status_flags (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chipEnableN,
    input wire logic outputEnableN,
    input wire logic opStart,
    input wire flash_status_pkg::opkind_t opKind,
    input wire logic ctrlActive,
    input wire logic ctrlPaused,
    input wire logic cmdSuspend,
    input wire logic cmdResume,
    input wire logic cmdClearStatus,
    input wire logic cmdReadStatus,
    input wire logic cmdReadArray,
    input wire logic opFail,
    input wire logic failVpp,
    input wire logic failProtected,
    input wire logic failSequence,
    input wire logic [7:0] arrayReadData,
    input wire logic burstConfigStored,
    output logic [7:0] dataLinesLowByte,
    output logic [7:0] dataLinesLowByteOe,
    output logic burstReadEnable
);
    import flash_status_pkg::*;

    // ------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------
    flag_if fl ();

    assign fl.opStart = opStart;
    assign fl.opKind = opKind;
    assign fl.ctrlActive = ctrlActive;
    assign fl.ctrlPaused = ctrlPaused;
    assign fl.cmdSuspend = cmdSuspend;
    assign fl.cmdResume = cmdResume;
    assign fl.cmdClear = cmdClearStatus;
    assign fl.opFail = opFail;
    assign fl.failVpp = failVpp;
    assign fl.failProtected = failProtected;
    assign fl.failSequence = failSequence;

    status_flags flagsInst (
        .mclk(mclk),
        .rst(rst),
        .fl(fl.flags)
    );

    logic [7:0] statusByte;

    assign statusByte = fl.statusByte;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // The bus strobes are asynchronous to mclk, so each passes two
    // flip-flops before any decode looks at it.
    logic ceSync1_reg, ceSync1_next;
    logic ceSync2_reg, ceSync2_next;
    logic oeSync1_reg, oeSync1_next;
    logic oeSync2_reg, oeSync2_next;

    always_comb begin
        ceSync1_next = chipEnableN;
        ceSync2_next = ceSync1_reg;
        oeSync1_next = outputEnableN;
        oeSync2_next = oeSync1_reg;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ceSync1_reg <= PIN_INACTIVE;
            ceSync2_reg <= PIN_INACTIVE;
            oeSync1_reg <= PIN_INACTIVE;
            oeSync2_reg <= PIN_INACTIVE;
        end else begin
            ceSync1_reg <= ceSync1_next;
            ceSync2_reg <= ceSync2_next;
            oeSync1_reg <= oeSync1_next;
            oeSync2_reg <= oeSync2_next;
        end
    end

    // ------------------------------------------------------------
    // Read mode
    // ------------------------------------------------------------
    readmode_t readMode_reg, readMode_next;
    logic burstEn_reg, burstEn_next;

    always_comb begin
        readMode_next = readMode_reg;
        if (cmdReadArray) begin
            readMode_next = MODE_ARRAY;
        end
        if (cmdReadStatus || opStart || cmdResume) begin
            readMode_next = MODE_STATUS;
        end
        // Burst reads are only allowed in array mode; the stored setting
        // comes back by itself once array mode is entered again.
        burstEn_next = (readMode_next == MODE_ARRAY) && burstConfigStored;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readMode_reg <= MODE_ARRAY;
            burstEn_reg <= 1'b0;
        end else begin
            readMode_reg <= readMode_next;
            burstEn_reg <= burstEn_next;
        end
    end

    assign burstReadEnable = burstEn_reg;

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    // The status byte is sampled once at the start of each read and then
    // held, so a slow host sees a stable value; it only sees new progress
    // after toggling output enable or re-selecting the chip.
    logic readActive;
    logic readActivePrev_reg, readActivePrev_next;
    logic readIsStatus_reg, readIsStatus_next;
    logic [7:0] dataOut_reg, dataOut_next;
    logic [7:0] dataOe_reg, dataOe_next;
    logic readStart;

    assign readActive = !ceSync2_reg && !oeSync2_reg;
    assign readStart = readActive && !readActivePrev_reg;

    always_comb begin
        readActivePrev_next = readActive;
        readIsStatus_next = readIsStatus_reg;
        dataOut_next = dataOut_reg;
        dataOe_next = NO_OE_MASK;
        if (readStart) begin
            readIsStatus_next = (readMode_reg == MODE_STATUS);
            // Status is decoded from any address, so no address is looked at.
            dataOut_next = (readMode_reg == MODE_STATUS) ? statusByte : arrayReadData;
        end else if (readActive && !readIsStatus_reg) begin
            dataOut_next = arrayReadData;
        end
        if (readActive) begin
            if (readIsStatus_next && !dataOut_next[BIT_IDLE]) begin
                dataOe_next = BUSY_OE_MASK;
            end else begin
                dataOe_next = FULL_OE_MASK;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readActivePrev_reg <= 1'b0;
            readIsStatus_reg <= 1'b0;
            dataOut_reg <= STATUS_RESET;
            dataOe_reg <= NO_OE_MASK;
        end else begin
            readActivePrev_reg <= readActivePrev_next;
            readIsStatus_reg <= readIsStatus_next;
            dataOut_reg <= dataOut_next;
            dataOe_reg <= dataOe_next;
        end
    end

    assign dataLinesLowByte = dataOut_reg;
    assign dataLinesLowByteOe = dataOe_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_newStatusRead;
        !readActive ##1 (readActive && readMode_reg == MODE_STATUS);
    endsequence

    sequence s_readHeld;
        readActive [*3];
    endsequence

    a_status_on_lines: assert property (s_newStatusRead |=> dataLinesLowByteOe[BIT_IDLE]
        && dataLinesLowByte == $past(statusByte)) else $error("status not driven at read start");

    a_auto_status_mode: assert property (opStart || cmdResume |=> readMode_reg == MODE_STATUS)
        else $error("status mode not entered");

    a_burst_restored: assert property (cmdReadArray && !cmdReadStatus && !opStart && !cmdResume
        && burstConfigStored |=> burstReadEnable) else $error("burst setting not restored");

    a_no_burst_status: assert property (readMode_reg == MODE_STATUS |-> !burstReadEnable)
        else $error("burst enabled during status mode");

    a_snapshot_held: assert property (s_readHeld ##0 readIsStatus_reg |-> $stable(dataLinesLowByte))
        else $error("status changed inside one read");

    a_busy_undriven: assert property (readIsStatus_reg && dataLinesLowByteOe != NO_OE_MASK
        && !dataLinesLowByte[BIT_IDLE] |-> dataLinesLowByteOe == BUSY_OE_MASK)
        else $error("busy status drives more than bit 7");

    a_idle_when_done: assert property (!ctrlActive ##1 (!ctrlActive && !cmdSuspend)
        |-> statusByte[BIT_IDLE]) else $error("idle bit low with controller stopped");

    a_oe_released: assert property (!readActive |=> dataLinesLowByteOe == NO_OE_MASK)
        else $error("lines driven outside a read");

endmodule // flash_op_status_flags

// [host_model.sv]
// Host memory controller model that runs asynchronous reads of the status byte.
`timescale 1ns/1ns
module host_model (
    input wire logic mclk,
    input wire logic [7:0] dataLinesLowByte,
    input wire logic [7:0] dataLinesLowByteOe,
    output logic chipEnableN,
    output logic outputEnableN
);
    initial begin
        chipEnableN = 1'b1;
        outputEnableN = 1'b1;
    end

    // ------------------------------------------------------------
    // Bus read cycles
    // ------------------------------------------------------------
    // Only plain asynchronous reads are issued; the model never starts a burst.
    task automatic readOpen();
        @(negedge mclk);
        chipEnableN = 1'b0;
        outputEnableN = 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    // The reserved bit is masked before anyone looks at the byte.
    task automatic readSample(output logic [7:0] data, output logic [7:0] oe);
        data = dataLinesLowByte & 8'hfe;
        oe = dataLinesLowByteOe;
    endtask

    // Output enable, and chip enable unless keepCe, stay high for four clocks so the next read is seen as a fresh one.
    task automatic readClose(input logic keepCe);
        outputEnableN = 1'b1;
        if (!keepCe) begin
            chipEnableN = 1'b1;
        end
        repeat (4) @(negedge mclk);
    endtask

    task automatic readByte(output logic [7:0] data, output logic [7:0] oe);
        readOpen();
        readSample(data, oe);
        readClose(1'b0);
    endtask
endmodule // host_model

// [flash_op_status_flags_tb_top.sv]
// Self-checking bench for the flash status flag block, with the host read model.
`timescale 1ns/1ns
module flash_op_status_flags_tb_top;
    import flash_status_pkg::*;
    logic mclk, rst, chipEnableN, outputEnableN, opStart, ctrlActive, ctrlPaused, cmdSuspend, cmdResume;
    logic cmdClearStatus, cmdReadStatus, cmdReadArray, opFail, failVpp, failProtected, failSequence;
    logic burstConfigStored, burstReadEnable;
    logic [7:0] arrayReadData, dataLinesLowByte, dataLinesLowByteOe, rd, ro;
    opkind_t opKind;
    int n_fail, checked;

    flash_op_status_flags u_dut (.mclk(mclk), .rst(rst), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .opStart(opStart), .opKind(opKind), .ctrlActive(ctrlActive),
        .ctrlPaused(ctrlPaused), .cmdSuspend(cmdSuspend), .cmdResume(cmdResume),
        .cmdClearStatus(cmdClearStatus), .cmdReadStatus(cmdReadStatus), .cmdReadArray(cmdReadArray),
        .opFail(opFail), .failVpp(failVpp), .failProtected(failProtected), .failSequence(failSequence),
        .arrayReadData(arrayReadData), .burstConfigStored(burstConfigStored),
        .dataLinesLowByte(dataLinesLowByte), .dataLinesLowByteOe(dataLinesLowByteOe),
        .burstReadEnable(burstReadEnable));
    host_model u_host (.mclk(mclk), .dataLinesLowByte(dataLinesLowByte),
        .dataLinesLowByteOe(dataLinesLowByteOe), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic sig);
        @(negedge mclk);
        sig = 1'b1;
        @(negedge mclk);
        sig = 1'b0;
    endtask

    task automatic startOp(input opkind_t kind);
        @(negedge mclk);
        opKind = kind;
        opStart = 1'b1;
        ctrlActive = 1'b1;
        @(negedge mclk);
        opStart = 1'b0;
    endtask

    // Bounded poll of the idle bit before any other bit is trusted.
    task automatic pollIdle();
        int n;
        n = 0;
        rd = 8'h00;
        while (rd[7] !== 1'b1 && n < 8) begin
            u_host.readByte(rd, ro);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_mode();
        u_host.readByte(rd, ro);
        check(rd, 8'h5a);
        check({7'h00, burstReadEnable}, 8'h01);
        pulse(cmdReadStatus);
        u_host.readByte(rd, ro);
        check(rd, 8'h80);
        check(ro, FULL_OE_MASK);
        check(dataLinesLowByteOe, NO_OE_MASK);
        check({7'h00, burstReadEnable}, 8'h00);
        pulse(cmdReadArray);
        u_host.readByte(rd, ro);
        check(rd, 8'h5a);
    endtask

    // The op is started from array mode each time, so the switch to status is exercised too.
    task automatic test_fail(input opkind_t kind, input logic [2:0] cause, input logic [7:0] exp);
        pulse(cmdClearStatus);
        pulse(cmdReadArray);
        startOp(kind);
        u_host.readByte(rd, ro);
        check(ro, BUSY_OE_MASK);
        check(rd & 8'h80, 8'h00);
        @(negedge mclk);
        {failVpp, failProtected, failSequence} = cause;
        opFail = 1'b1;
        ctrlActive = 1'b0;
        @(negedge mclk);
        opFail = 1'b0;
        pollIdle();
        check(rd, exp);
        u_host.readByte(rd, ro);
        check(rd, exp);
    endtask

    task automatic test_suspend(input opkind_t kind, input logic paused, input logic [7:0] exp);
        startOp(kind);
        pulse(cmdSuspend);
        u_host.readByte(rd, ro);
        check(ro, BUSY_OE_MASK);
        @(negedge mclk);
        ctrlPaused = paused;
        ctrlActive = 1'b0;
        @(negedge mclk);
        ctrlPaused = 1'b0;
        u_host.readByte(rd, ro);
        check(rd, exp);
        pulse(cmdReadArray);
        pulse(cmdResume);
        u_host.readByte(rd, ro);
        check(rd, 8'h80);
    endtask

    // One read holds its sample; a fresh enable edge shows the new state.
    task automatic test_refresh(input logic keepCe);
        startOp(OP_ERASE);
        u_host.readOpen();
        u_host.readSample(rd, ro);
        check(ro, BUSY_OE_MASK);
        @(negedge mclk);
        ctrlActive = 1'b0;
        repeat (4) @(negedge mclk);
        u_host.readSample(rd, ro);
        check(ro, BUSY_OE_MASK);
        u_host.readClose(keepCe);
        u_host.readOpen();
        u_host.readSample(rd, ro);
        check(ro, FULL_OE_MASK);
        check(rd, 8'h80);
        u_host.readClose(1'b0);
    endtask

    // A mid-run reset drops the sticky flags; a refused suspend and live array data come first and last.
    task automatic test_reset();
        startOp(OP_ERASE);
        @(negedge mclk);
        {failVpp, failProtected, failSequence} = 3'b100;
        opFail = 1'b1;
        ctrlActive = 1'b0;
        @(negedge mclk);
        opFail = 1'b0;
        pulse(cmdSuspend);
        u_host.readByte(rd, ro);
        check(ro, FULL_OE_MASK);
        check(rd, 8'ha8);
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check({7'h00, burstReadEnable}, 8'h00);
        pulse(cmdReadStatus);
        u_host.readByte(rd, ro);
        check(rd, 8'h80);
        burstConfigStored = 1'b0;
        pulse(cmdReadArray);
        check({7'h00, burstReadEnable}, 8'h00);
        u_host.readOpen();
        u_host.readSample(rd, ro);
        check(rd, 8'h5a);
        arrayReadData = 8'h3c;
        repeat (2) @(negedge mclk);
        u_host.readSample(rd, ro);
        check(rd, 8'h3c);
        u_host.readClose(1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {opStart, ctrlActive, ctrlPaused, cmdSuspend, cmdResume, cmdClearStatus} = 6'h00;
        {cmdReadStatus, cmdReadArray, opFail, failVpp, failProtected, failSequence} = 6'h00;
        opKind = OP_WORD_PROGRAM;
        arrayReadData = 8'h5a;
        burstConfigStored = 1'b1;
        n_fail = 0;
        checked = 0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        test_mode();
        test_fail(OP_ERASE, 3'b000, 8'ha0);
        test_fail(OP_ERASE, 3'b100, 8'ha8);
        test_fail(OP_ERASE, 3'b010, 8'ha2);
        test_fail(OP_ERASE, 3'b001, 8'hb0);
        test_fail(OP_UNPROTECT, 3'b100, 8'ha8);
        test_fail(OP_WORD_PROGRAM, 3'b000, 8'h90);
        test_fail(OP_WORD_PROGRAM, 3'b100, 8'h98);
        test_fail(OP_WORD_PROGRAM, 3'b010, 8'h92);
        test_fail(OP_WORD_PROGRAM, 3'b001, 8'hb0);
        test_fail(OP_BUFFER_PROGRAM, 3'b100, 8'h90);
        test_fail(OP_PROTECT, 3'b100, 8'h98);
        pulse(cmdClearStatus);
        u_host.readByte(rd, ro);
        check(rd, 8'h80);
        test_suspend(OP_ERASE, 1'b1, 8'hc0);
        test_suspend(OP_WORD_PROGRAM, 1'b1, 8'h84);
        test_suspend(OP_ERASE, 1'b0, 8'h80);
        test_refresh(1'b1);
        test_refresh(1'b0);
        test_reset();
        test_done();
    end

    // The full sequence needs well under a tenth of this span.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        test_done();
    end
endmodule // flash_op_status_flags_tb_top
